// file: rtl/smbus_ext_slave.sv
// SMBus alert response, clock-low timeout and general call decoder
`timescale 1ns/100ps
`default_nettype none
`include "smbus_ext_defines.svh"
module smbus_ext_slave #(
	parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC,
	parameter int TPOR_CYCLES = `TPOR_CYC
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_B_O,
	input wire logic [2:0] ADDRESS_SELECT_PINS_I,
	input wire logic ALARM_INTERRUPT_MODE_BIT_I,
	input wire logic ALERT_POLARITY_BIT_I,
	input wire logic ALARM_EVENT_I,
	input wire logic ALARM_HIGH_LIMIT_I,
	output logic ALERT_O,
	output logic ALERT_OE_B_O,
	output logic BUSY_O,
	output logic NV_COPY_O,
	output logic [2:0] BUS_ADDR_O,
	output logic TIMEOUT_O
);
	// ==========================================================
	// Input synchronisers
	smbus_ext_pkg::bus_lines_t s1_r, s2_r, s3_r;
	logic [2:0] pin1_r, pin2_r;
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s1_r <= 2'h3;
			s2_r <= 2'h3;
			s3_r <= 2'h3;
			pin1_r <= 3'h0;
			pin2_r <= 3'h0;
		end else begin
			s1_r <= '{scl: SCL_I, sda: SDA_I};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin1_r <= ADDRESS_SELECT_PINS_I;
			pin2_r <= pin1_r;
		end
	end
	wire scl_rise = s2_r.scl && !s3_r.scl;
	wire scl_fall = !s2_r.scl && s3_r.scl;
	wire start_c = s3_r.scl && s2_r.scl && s3_r.sda && !s2_r.sda;
	wire stop_c = s3_r.scl && s2_r.scl && !s3_r.sda && s2_r.sda;

	function automatic logic [6:0] own_addr(input logic [2:0] a);
		own_addr = {`ADDR_PREFIX, a};
	endfunction

	// ==========================================================
	// Link state
	smbus_ext_pkg::link_state_t st_r, st_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic drive_low_r, drive_low_nxt;
	logic gc_r, gc_nxt;
	logic [2:0] addr_r, addr_nxt;
	logic alert_r, alert_nxt;
	logic limit_r, limit_nxt;
	logic started_r, started_nxt;
	logic [31:0] to_cnt_r, to_cnt_nxt;
	logic [31:0] busy_cnt_r, busy_cnt_nxt;
	logic nv_r, nv_nxt;
	logic to_r, to_nxt;
	logic smb_alert_en;

	always_comb begin
		smb_alert_en = ALARM_INTERRUPT_MODE_BIT_I && !ALERT_POLARITY_BIT_I;
		st_nxt = st_r;
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		drive_low_nxt = drive_low_r;
		gc_nxt = gc_r;
		addr_nxt = addr_r;
		alert_nxt = alert_r;
		limit_nxt = limit_r;
		started_nxt = started_r;
		nv_nxt = 1'b0;
		to_nxt = 1'b0;
		busy_cnt_nxt = busy_cnt_r;
		if (busy_cnt_r != 32'h0)
			busy_cnt_nxt = busy_cnt_r - 32'h1;
		if (ALARM_EVENT_I && smb_alert_en) begin
			alert_nxt = 1'b1;
			limit_nxt = ALARM_HIGH_LIMIT_I;
		end
		if (!smb_alert_en)
			alert_nxt = 1'b0;
		// Timeout counts only while a frame is open, clock low
		to_cnt_nxt = (s2_r.scl || !started_r) ? 32'h0 : to_cnt_r + 32'h1;
		if (to_cnt_r >= TIMEOUT_CYCLES - 1) begin
			st_nxt = smbus_ext_pkg::ST_IDLE;
			drive_low_nxt = 1'b0;
			started_nxt = 1'b0;
			to_cnt_nxt = 32'h0;
			to_nxt = 1'b1;
		end else if (start_c) begin
			st_nxt = smbus_ext_pkg::ST_ADDR;
			bit_nxt = 4'h0;
			drive_low_nxt = 1'b0;
			started_nxt = 1'b1;
		end else if (stop_c) begin
			st_nxt = smbus_ext_pkg::ST_IDLE;
			drive_low_nxt = 1'b0;
			started_nxt = 1'b0;
		end else begin
			case (st_r)
				smbus_ext_pkg::ST_ADDR, smbus_ext_pkg::ST_CMD: begin
					if (scl_rise) begin
						sh_nxt = {sh_r[6:0], s2_r.sda};
						bit_nxt = bit_r + 4'h1;
					end
					if (scl_fall && bit_r == 4'h8) begin
						bit_nxt = 4'h0;
						if (st_r == smbus_ext_pkg::ST_ADDR) begin
							gc_nxt = 1'b0;
							st_nxt = smbus_ext_pkg::ST_WAIT;
							if (sh_r == `ARA_BYTE && alert_r) begin
								drive_low_nxt = 1'b1;
								st_nxt = smbus_ext_pkg::ST_ACK_ADDR;
							end else if (sh_r == `GCALL_BYTE) begin
								drive_low_nxt = 1'b1;
								gc_nxt = 1'b1;
								st_nxt = smbus_ext_pkg::ST_ACK_ADDR;
							end else if (sh_r[7:1] == own_addr(addr_r) && busy_cnt_r == 32'h0) begin
								drive_low_nxt = 1'b1;
								st_nxt = smbus_ext_pkg::ST_OWN;
							end
						end else begin
							st_nxt = smbus_ext_pkg::ST_ACK_CMD;
							if (sh_r == `CMD_RELATCH) begin
								addr_nxt = pin2_r;
								drive_low_nxt = 1'b1;
							end else if (sh_r == `CMD_GC_RESET) begin
								addr_nxt = pin2_r;
								nv_nxt = 1'b1;
								busy_cnt_nxt = 32'(TPOR_CYCLES);
								drive_low_nxt = 1'b1;
							end else begin
								st_nxt = smbus_ext_pkg::ST_WAIT;
							end
						end
					end
				end
				smbus_ext_pkg::ST_ACK_ADDR: begin
					if (scl_fall) begin
						drive_low_nxt = 1'b0;
						if (gc_r) begin
							st_nxt = smbus_ext_pkg::ST_CMD;
						end else begin
							sh_nxt = {own_addr(addr_r), limit_r};
							drive_low_nxt = !sh_nxt[7];
							bit_nxt = 4'h1;
							st_nxt = smbus_ext_pkg::ST_ARA_TX;
						end
					end
				end
				smbus_ext_pkg::ST_ARA_TX: begin
					if (scl_rise && !drive_low_r && !s2_r.sda)
						st_nxt = smbus_ext_pkg::ST_WAIT;
					else if (scl_fall) begin
						if (bit_r == 4'h8) begin
							drive_low_nxt = 1'b0;
							alert_nxt = 1'b0;
							st_nxt = smbus_ext_pkg::ST_ARA_ACKW;
						end else begin
							drive_low_nxt = !sh_r[7 - bit_r[2:0]];
							bit_nxt = bit_r + 4'h1;
						end
					end
				end
				smbus_ext_pkg::ST_ACK_CMD, smbus_ext_pkg::ST_OWN: begin
					if (scl_fall) begin
						drive_low_nxt = 1'b0;
						st_nxt = smbus_ext_pkg::ST_WAIT;
					end
				end
				smbus_ext_pkg::ST_ARA_ACKW, smbus_ext_pkg::ST_WAIT, smbus_ext_pkg::ST_IDLE: begin
					drive_low_nxt = 1'b0;
				end
				default: begin
					st_nxt = smbus_ext_pkg::ST_IDLE;
					drive_low_nxt = 1'b0;
				end
			endcase
		end
		// Arbitration loss leaves the alert latched; a new event still wins
		if (ALARM_EVENT_I && smb_alert_en)
			alert_nxt = 1'b1;
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_r <= smbus_ext_pkg::ST_IDLE;
			sh_r <= 8'h00;
			bit_r <= 4'h0;
			drive_low_r <= 1'b0;
			gc_r <= 1'b0;
			addr_r <= 3'h0;
			alert_r <= 1'b0;
			limit_r <= 1'b0;
			started_r <= 1'b0;
			to_cnt_r <= 32'h0;
			busy_cnt_r <= 32'h0;
			nv_r <= 1'b0;
			to_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
			drive_low_r <= drive_low_nxt;
			gc_r <= gc_nxt;
			addr_r <= addr_nxt;
			alert_r <= alert_nxt;
			limit_r <= limit_nxt;
			started_r <= started_nxt;
			to_cnt_r <= to_cnt_nxt;
			busy_cnt_r <= busy_cnt_nxt;
			nv_r <= nv_nxt;
			to_r <= to_nxt;
		end
	end

	// ==========================================================
	// Outputs, data and alert open drain: enable low drives zero
	assign SDA_O = 1'b0;
	assign SDA_OE_B_O = !drive_low_r;
	assign ALERT_O = 1'b0;
	assign ALERT_OE_B_O = !alert_r;
	assign BUSY_O = busy_cnt_r != 32'h0;
	assign NV_COPY_O = nv_r;
	assign BUS_ADDR_O = addr_r;
	assign TIMEOUT_O = to_r;
endmodule
`default_nettype wire

// file: shared/smbus_ext_defines.svh
// Constants for the SMBus alert, timeout and general call slave logic
// Overview of operation
// - Alert function works only in interrupt mode with active-low polarity.
// - Master sends alert response address; alerting device acknowledges it.
// - Device then returns its seven-bit address: prefix plus latched select pins.
// - Last bit of that byte: 1 for high limit, 0 for low limit.
// - Several responders arbitrate on data line; lowest address wins.
// - Winner releases its alert after sending its address.
// - Loser does not acknowledge and keeps its alert asserted.
// - Clock low beyond minimum timeout resets interface and releases data line.
// - After timeout reset a new start is recognised before maximum timeout.
// - General call acknowledged only with write bit zero, then await command.
// - Re-latch command makes device resample address pins as new address.
// - Reset command resamples address pins then runs internal reset.
// - Reset copies nonvolatile registers to volatile ones within power-on time.
// - While busy the device does not acknowledge its own address.
`ifndef SMBUS_EXT_DEFINES_SVH
`define SMBUS_EXT_DEFINES_SVH
`define ARA_BYTE 8'h19
`define GCALL_BYTE 8'h00
`define CMD_RELATCH 8'h04
`define CMD_GC_RESET 8'h06
`define ADDR_PREFIX 4'h9
`define CLK_PERIOD_NS 25
`define TIMEOUT_MIN_US 25
`define TIMEOUT_CYC ((`TIMEOUT_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TPOR_US 1000
`define TPOR_CYC ((`TPOR_US * 1000) / `CLK_PERIOD_NS)
`define NV_REG_COUNT 4
`endif

// file: shared/smbus_ext_pkg.sv
// Types for the SMBus alert, timeout and general call slave logic
package smbus_ext_pkg;
	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_ARA_TX,
		ST_ARA_ACKW,
		ST_CMD,
		ST_ACK_CMD,
		ST_OWN,
		ST_WAIT
	} link_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;
	typedef struct packed {
		logic interrupt_mode;
		logic polarity;
	} alarm_cfg_t;
endpackage

// file: bench/smbus_ext_slave_assertions.sv
// Concurrent checks on the SMBus alert, timeout and general call logic
`timescale 1ns/100ps
`default_nettype none
module smbus_ext_slave_assertions #(
	parameter int TIMEOUT_CYCLES = 1000,
	parameter int TPOR_CYCLES = 40000
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_B_O,
	input wire logic [2:0] ADDRESS_SELECT_PINS_I,
	input wire logic ALARM_INTERRUPT_MODE_BIT_I,
	input wire logic ALERT_POLARITY_BIT_I,
	input wire logic ALARM_EVENT_I,
	input wire logic ALERT_O,
	input wire logic ALERT_OE_B_O,
	input wire logic BUSY_O,
	input wire logic NV_COPY_O,
	input wire logic [2:0] BUS_ADDR_O,
	input wire logic TIMEOUT_O
);
	// ====
	// Cycle counters
	logic [15:0] lo_r, lo_nxt, busy_r, busy_nxt;
	always_comb begin
		lo_nxt = SCL_I ? 16'h0000 : lo_r + 16'(lo_r != 16'hFFFF);
		busy_nxt = BUSY_O ? busy_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lo_r <= 16'h0000;
			busy_r <= 16'h0000;
		end else begin
			lo_r <= lo_nxt;
			busy_r <= busy_nxt;
		end
	end
	default clocking @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	// ====
	// Properties
	property p_alert_off;
		!ALARM_INTERRUPT_MODE_BIT_I || ALERT_POLARITY_BIT_I |-> ##[1:2] ALERT_OE_B_O;
	endproperty
	a_alert_off: assert property (p_alert_off) else $error("alert driven while disabled");
	property p_alert_on;
		ALARM_EVENT_I && ALARM_INTERRUPT_MODE_BIT_I && !ALERT_POLARITY_BIT_I |-> ##[1:3] !ALERT_OE_B_O;
	endproperty
	a_alert_on: assert property (p_alert_on) else $error("alert not raised");
	// Lag of three comes from the input synchroniser
	property p_sda_edge;
		$changed(SDA_OE_B_O) |-> !$past(SCL_I, 2) || !$past(SCL_I, 3) || !$past(SCL_I, 4);
	endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("data moved while clock high");
	property p_open_drain;
		!SDA_O && !ALERT_O;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");
	property p_to_release;
		TIMEOUT_O |-> ##1 SDA_OE_B_O [*4];
	endproperty
	a_to_release: assert property (p_to_release) else $error("data held after timeout");
	property p_to_cause;
		TIMEOUT_O |-> int'(lo_r) >= TIMEOUT_CYCLES;
	endproperty
	a_to_cause: assert property (p_to_cause) else $error("early timeout");
	property p_copy;
		$rose(NV_COPY_O) |-> ##[0:1] (BUSY_O && BUS_ADDR_O == ADDRESS_SELECT_PINS_I);
	endproperty
	a_copy: assert property (p_copy) else $error("copy without busy or relatch");
	property p_busy_bound;
		BUSY_O |-> int'(busy_r) < TPOR_CYCLES;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule
bind smbus_ext_slave smbus_ext_slave_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .TPOR_CYCLES(TPOR_CYCLES)) chk_u (
	.CORE_CLK_I, .RST_B_I, .SCL_I, .SDA_O, .SDA_OE_B_O, .ADDRESS_SELECT_PINS_I, .ALARM_INTERRUPT_MODE_BIT_I,
	.ALERT_POLARITY_BIT_I, .ALARM_EVENT_I, .ALERT_O, .ALERT_OE_B_O, .BUSY_O, .NV_COPY_O, .BUS_ADDR_O, .TIMEOUT_O);
`default_nettype wire

// file: bench/smbus_master_model.sv
// Bus master model: clock and data with a pulled-up data line
`timescale 1ns/100ps
`default_nettype none
module smbus_master_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// ====
	// Bit level: data moves mid-low so it never mimics start or stop
	task automatic bit_x(input logic b, output logic r);
		scl_o <= 1'b0;
		w(2);
		sda_o <= b;
		w(2);
		scl_o <= 1'b1;
		w(2);
		r = sda_i;
		w(2);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [8:0] r);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i + 1]);
		bit_x(1'b1, r[0]);
	endtask
	task automatic start;
		sda_o <= 1'b1;
		w(2);
		scl_o <= 1'b1;
		w(4);
		sda_o <= 1'b0;
		w(4);
	endtask
	task automatic stop;
		scl_o <= 1'b0;
		w(2);
		sda_o <= 1'b0;
		w(2);
		scl_o <= 1'b1;
		w(4);
		sda_o <= 1'b1;
		w(4);
	endtask
	task automatic hold(input int n);
		scl_o <= 1'b0;
		w(n);
	endtask
endmodule
`default_nettype wire

// file: bench/smbus_ext_slave_tb.sv
// Self-checking bench for the SMBus alert, timeout and general call logic
`timescale 1ns/100ps
`default_nettype none
module smbus_ext_slave_tb;
	logic clk, rst_b, scl, msda, mode, alert_polarity_bit, evt, hi, sda_o, sda_oe_b, alert_oe_b, busy, to;
	logic to_seen = 1'b0;
	logic nv;
	logic nv_seen = 1'b0;
	logic [2:0] pins, addr;
	logic [8:0] r;
	int mismatches = 0;
	int comparisons = 0;
	wire logic sda;
	assign sda = msda & (sda_oe_b | sda_o);
	smbus_ext_slave #(.TIMEOUT_CYCLES(40), .TPOR_CYCLES(200)) dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b),
		.SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_B_O(sda_oe_b), .ADDRESS_SELECT_PINS_I(pins),
		.ALARM_INTERRUPT_MODE_BIT_I(mode), .ALERT_POLARITY_BIT_I(alert_polarity_bit), .ALARM_EVENT_I(evt),
		.ALARM_HIGH_LIMIT_I(hi), .ALERT_O(), .ALERT_OE_B_O(alert_oe_b), .BUSY_O(busy), .NV_COPY_O(nv),
		.BUS_ADDR_O(addr), .TIMEOUT_O(to));
	smbus_master_model mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(msda));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) if (to) to_seen <= 1'b1;
	always @(posedge clk) if (nv) nv_seen <= 1'b1;
	// ====
	// Tasks
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic gc(input logic [7:0] a, input logic [7:0] c, input logic [1:0] e);
		logic k;
		mst_u.start;
		mst_u.xfer(a, r);
		k = r[0];
		mst_u.xfer(c, r);
		mst_u.stop;
		chk("gc acks", 9'(e), 9'({k, r[0]}));
	endtask
	task automatic one(input logic [7:0] a, input logic e);
		mst_u.start;
		mst_u.xfer(a, r);
		mst_u.stop;
		chk("own ack", 9'(e), 9'(r[0]));
	endtask
	task automatic ara(input logic [7:0] d, input logic [7:0] e, input logic a);
		mst_u.start;
		mst_u.xfer(8'h19, r);
		chk("ara ack", {8'h19, a}, r);
		mst_u.xfer(d, r);
		mst_u.stop;
		chk("reply", {e, 1'b1}, r);
	endtask
	task automatic alarm(input logic h);
		hi <= h;
		evt <= 1'b1;
		@(posedge clk);
		evt <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// ====
	// Tests
	initial begin
		rst_b = 1'b0;
		mode = 1'b1;
		alert_polarity_bit = 1'b0;
		evt = 1'b0;
		hi = 1'b0;
		pins = 3'h5;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		gc(8'h00, 8'h06, 2'h0);
		chk("addr", 9'h005, 9'(addr));
		chk("busy", 9'h001, 9'(busy));
		chk("nv copy", 9'h001, 9'(nv_seen));
		one(8'h9A, 1'b1);
		for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
		chk("busy", 9'h000, 9'(busy));
		if (busy !== 1'b0) finish_test;
		one(8'h9A, 1'b0);
		pins <= 3'h2;
		gc(8'h00, 8'h04, 2'h0);
		chk("addr", 9'h002, 9'(addr));
		pins <= 3'h7;
		gc(8'h00, 8'h05, 2'h1);
		gc(8'h01, 8'h04, 2'h3);
		chk("addr", 9'h002, 9'(addr));
		$display("test general call done");
		for (int h = 0; h < 2; h++) begin
			alarm(h[0]);
			chk("alert", 9'h000, 9'(alert_oe_b));
			ara(8'hFF, {4'h9, 3'h2, h[0]}, 1'b0);
			chk("alert", 9'h001, 9'(alert_oe_b));
		end
		alarm(1'b1);
		ara(8'h91, 8'h91, 1'b0);
		chk("alert", 9'h000, 9'(alert_oe_b));
		ara(8'hFF, 8'h95, 1'b0);
		chk("alert", 9'h001, 9'(alert_oe_b));
		$display("test alert response done");
		alarm(1'b0);
		mst_u.start;
		mst_u.xfer(8'h19, r);
		mst_u.bit_x(1'b1, r[0]);
		mst_u.bit_x(1'b1, r[0]);
		mst_u.hold(60);
		chk("sda release", 9'h001, 9'(sda_oe_b));
		chk("timeout", 9'h001, 9'(to_seen));
		gc(8'h00, 8'h04, 2'h0);
		$display("test timeout done");
		alert_polarity_bit <= 1'b1;
		repeat (4) @(posedge clk);
		chk("alert", 9'h001, 9'(alert_oe_b));
		ara(8'hFF, 8'hFF, 1'b1);
		$display("test disabled alert done");
		finish_test;
	end
endmodule
`default_nettype wire
